// *** shared/system_clock_pll_map.vh ***
// Register offsets, field positions, reset values and timing counts of the PLL control block
`ifndef SYSTEM_CLOCK_PLL_MAP_VH
`define SYSTEM_CLOCK_PLL_MAP_VH

// Register byte offsets
`define OFS_PLL_CONTROL      12'h100
`define OFS_FEEDBACK_DIV     12'h101
`define OFS_PREDIV           12'h102
`define OFS_PERIOD_0         12'h103
`define OFS_PERIOD_1         12'h104
`define OFS_PERIOD_2         12'h105
`define OFS_STAB_0           12'h106
`define OFS_STAB_1           12'h107
`define OFS_STAB_2           12'h108
`define OFS_IRQ_MASK         12'h209
`define OFS_CAL_SYNC         12'hA02
`define OFS_CLOCK_STATUS     12'hD01
`define OFS_IRQ_MONITOR      12'hD02

// pll_control fields
`define CTL_LOCK_SEL_LSB     0
`define CTL_LOCK_DET_OFF     2
`define CTL_CP_CUR_LSB       3
`define CTL_CP_MANUAL        6
`define CTL_EXT_FILTER       7
// Default pump code 3 gives the 500 uA setting
`define CTL_RESET_VALUE      8'h18

// Other fields
`define CAL_START_BIT        0
`define STAT_CAL_BUSY        1
`define STAT_LOCKED          0
`define STAT_STABLE          4
`define STAT_PLL_ENABLED     5
`define FB_DIV_MIN           8'h06
`define FB_DIV_RESET         8'h28
`define PREDIV_RESET         2'h0

// Length of one VCO calibration in clock cycles
`define CAL_RUN_CYCLES       64

// Lock run threshold base (128 samples)
`define LOCK_RUN_BASE        11'h080

// One millisecond at 50 MHz
`define MS_TIME_NS           1000000
`define CLK_PERIOD_NS        20
`define MS_CYCLES            (`MS_TIME_NS / `CLK_PERIOD_NS)

`endif

// *** rtl/lock_detect.v ***
// Consecutive in-phase run counter that declares PLL lock
`default_nettype none
`include "system_clock_pll_map.vh"

module lock_detect
(
    // Clock and reset
    input  wire       clk,
    input  wire       reset,
    // Control
    input  wire       enable,
    input  wire [1:0] threshold_sel,
    input  wire       restart,
    // Phase detector samples
    input  wire       sample_valid,
    input  wire       in_phase,
    // Result
    output reg        locked
);

    reg  [10:0] run_count;
    wire [10:0] threshold;

    assign threshold = `LOCK_RUN_BASE << threshold_sel;

    always @(posedge clk)
    begin
        if (reset || !enable || restart)
        begin
            run_count <= 11'h000;
            locked    <= 1'b0;
        end
        else if (sample_valid)
        begin
            if (!in_phase)
            begin
                // Any miss starts the run over and drops lock
                run_count <= 11'h000; // RULE_03
                locked    <= 1'b0;    // RULE_20
            end
            else if (run_count + 11'h001 >= threshold)
            begin
                run_count <= threshold;
                locked    <= 1'b1;    // RULE_02
            end
            else
            begin
                run_count <= run_count + 11'h001; // RULE_03
            end
        end
    end

endmodule
`default_nettype wire

// *** rtl/system_clock_pll_control.v ***
// Register file, charge pump selection and stability timer of the system clock PLL
//
// The address-and-strobe port was left to the implementer.
`default_nettype none
`include "system_clock_pll_map.vh"

// Operation
// RULE_01 - control bit 2 low enables lock detector
// RULE_02 - lock after 128/256/512/1024 in-phase samples
// RULE_03 - one sample per cycle; miss restarts count
// RULE_04 - software zeroes timer when detector disabled
// RULE_05 - auto mode picks current from divider
// RULE_06 - manual mode uses three-bit current field
// RULE_07 - bit 7 selects external loop filter
// RULE_08 - feedback divider accepts 6 through 255
// RULE_09 - software programs 21-bit clock period
// RULE_10 - stability timer holds 20-bit milliseconds
// RULE_11 - zero duration expires immediately
// RULE_12 - enabled PLL: timer starts at lock
// RULE_13 - disabled PLL: timer starts at disable
// RULE_14 - expiry shown in status bit 4
// RULE_15 - software sets duration before enable change
// RULE_16 - set-then-clear bit 0 starts calibration
// RULE_17 - calibration status, masked into monitor
// RULE_18 - reference monitors held off until stable
// RULE_19 - predivider ratios 1, 2, 4, 8
// RULE_20 - lock loss or calibration restarts qualification
module system_clock_pll_control
#(
    parameter MS_CYCLES  = `MS_CYCLES,
    parameter CAL_CYCLES = `CAL_RUN_CYCLES
)
(
    // Clock and reset
    input  wire        clk,
    input  wire        reset,
    // Register port
    input  wire [11:0] address,
    input  wire [7:0]  write_data,
    input  wire        write_strobe,
    input  wire        read_strobe,
    output reg  [7:0]  read_data,
    // PLL analog side
    input  wire        pll_enable,
    input  wire        pfd_sample_valid,
    input  wire        pfd_in_phase,
    output reg  [2:0]  cp_current,
    output reg         ext_loop_filter,
    output reg  [7:0]  feedback_div,
    output reg  [1:0]  predivider_log2,
    output reg         vco_cal_run,
    // Status to the rest of the chip
    output reg         pll_locked,
    output reg         pll_stable,
    output reg         ref_monitor_enable,
    output reg  [20:0] system_clock_period
);

    ////////////////////////////////////////////////////////////////////////
    // Registers

    reg  [7:0]  pll_control;
    reg  [19:0] stability_timer_duration;
    reg  [7:0]  calibration_sync_control;
    reg  [7:0]  irq_mask;
    reg  [19:0] ms_elapsed;
    reg  [31:0] ms_tick_count;
    reg         timing;
    reg         was_enabled;
    reg         was_locked;
    reg  [15:0] cal_count;
    reg         cal_busy;
    wire        detector_locked;
    wire        cal_start;
    wire        timer_start;
    reg  [7:0]  clock_status;
    reg  [7:0]  next_read_data;

    // Terminal counts; CAL_CYCLES must not exceed 65536
    localparam [15:0] CAL_LAST = CAL_CYCLES[15:0] - 16'h0001;
    localparam [31:0] MS_LAST  = MS_CYCLES - 1;

    // Falling edge of the start bit launches calibration
    assign cal_start = calibration_sync_control[`CAL_START_BIT]
                       && write_strobe && (address == `OFS_CAL_SYNC)
                       && !write_data[`CAL_START_BIT]; // RULE_16

    // Automatic current: larger divide ratio needs more pump current
    function [2:0] auto_current;
        input [7:0] div;
        begin
            if (div < 8'h20)
                auto_current = 3'h1;
            else if (div < 8'h40)
                auto_current = 3'h3;
            else if (div < 8'h80)
                auto_current = 3'h5;
            else
                auto_current = 3'h7;
        end
    endfunction

    always @(posedge clk)
    begin
        if (reset)
        begin
            pll_control              <= `CTL_RESET_VALUE;
            feedback_div             <= `FB_DIV_RESET;
            predivider_log2          <= `PREDIV_RESET;
            system_clock_period      <= 21'h000000;
            stability_timer_duration <= 20'h00000;
            calibration_sync_control <= 8'h00;
            irq_mask                 <= 8'h00;
        end
        else if (write_strobe)
        begin
            case (address)
                `OFS_PLL_CONTROL: pll_control <= write_data;
                `OFS_FEEDBACK_DIV:
                begin
                    // Values below the minimum are refused
                    if (write_data >= `FB_DIV_MIN)
                        feedback_div <= write_data; // RULE_08
                end
                `OFS_PREDIV:      predivider_log2 <= write_data[1:0]; // RULE_19
                `OFS_PERIOD_0:    system_clock_period[7:0]   <= write_data; // RULE_09
                `OFS_PERIOD_1:    system_clock_period[15:8]  <= write_data;
                `OFS_PERIOD_2:    system_clock_period[20:16] <= write_data[4:0];
                // Bytes land one at a time, so a half-written duration is live
                `OFS_STAB_0:      stability_timer_duration[7:0]   <= write_data; // RULE_10
                `OFS_STAB_1:      stability_timer_duration[15:8]  <= write_data;
                `OFS_STAB_2:      stability_timer_duration[19:16] <= write_data[3:0];
                `OFS_CAL_SYNC:    calibration_sync_control <= write_data;
                `OFS_IRQ_MASK:    irq_mask <= write_data;
                default:          pll_control <= pll_control;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock detector

    // Calibration holds the detector cleared, so lock is earned again afterwards
    lock_detect lock_detect_i
    (
        .clk           (clk),
        .reset         (reset),
        .enable        (!pll_control[`CTL_LOCK_DET_OFF]), // RULE_01
        .threshold_sel (pll_control[`CTL_LOCK_SEL_LSB +: 2]),
        .restart       (cal_start || cal_busy),            // RULE_20
        .sample_valid  (pfd_sample_valid),
        .in_phase      (pfd_in_phase),
        .locked        (detector_locked)
    );

    ////////////////////////////////////////////////////////////////////////
    // Charge pump, filter, calibration

    always @(posedge clk)
    begin
        if (reset)
        begin
            cp_current      <= 3'h3;
            ext_loop_filter <= 1'b0;
            cal_busy        <= 1'b0;
            cal_count       <= 16'h0000;
            vco_cal_run     <= 1'b0;
        end
        else
        begin
            if (pll_control[`CTL_CP_MANUAL])
                cp_current <= pll_control[`CTL_CP_CUR_LSB +: 3]; // RULE_06
            else
                cp_current <= auto_current(feedback_div); // RULE_05
            ext_loop_filter <= pll_control[`CTL_EXT_FILTER]; // RULE_07
            if (cal_start)
            begin
                cal_busy  <= 1'b1; // RULE_16
                cal_count <= 16'h0000;
            end
            else if (cal_busy)
            begin
                if (cal_count == CAL_LAST)
                    cal_busy <= 1'b0;
                cal_count <= cal_count + 16'h0001;
            end
            vco_cal_run <= cal_start
                           || (cal_busy && cal_count != CAL_LAST);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stability timer

    // Start on lock when enabled, on the disable edge otherwise
    assign timer_start = pll_enable ? (detector_locked && !was_locked)  // RULE_12
                                    : (was_enabled && !pll_enable);     // RULE_13

    always @(posedge clk)
    begin
        if (reset)
        begin
            was_enabled   <= 1'b0;
            was_locked    <= 1'b0;
            timing        <= 1'b0;
            ms_elapsed    <= 20'h00000;
            ms_tick_count <= 32'h00000000;
            pll_stable    <= 1'b0;
        end
        else
        begin
            was_enabled <= pll_enable;
            was_locked  <= detector_locked;
            if (stability_timer_duration == 20'h00000)
            begin
                // Zero duration reports stable with no counting
                timing     <= 1'b0;
                pll_stable <= 1'b1; // RULE_11
            end
            else if (cal_start || (pll_enable && !detector_locked))
            begin
                // Lost lock or new calibration requalifies
                timing        <= 1'b0; // RULE_20
                pll_stable    <= 1'b0;
                ms_elapsed    <= 20'h00000;
                ms_tick_count <= 32'h00000000;
            end
            // A new start event counts again from zero
            else if (timer_start)
            begin
                timing        <= 1'b1;
                pll_stable    <= 1'b0;
                ms_elapsed    <= 20'h00000;
                ms_tick_count <= 32'h00000000;
            end
            else if (timing)
            begin
                if (ms_tick_count == MS_LAST)
                begin
                    ms_tick_count <= 32'h00000000;
                    if (ms_elapsed + 20'h00001 == stability_timer_duration)
                    begin
                        timing     <= 1'b0;
                        pll_stable <= 1'b1; // RULE_12
                    end
                    ms_elapsed <= ms_elapsed + 20'h00001;
                end
                else
                    ms_tick_count <= ms_tick_count + 32'h00000001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status and read port

    always @*
    begin
        clock_status                    = 8'h00;
        clock_status[`STAT_LOCKED]      = detector_locked;
        clock_status[`STAT_CAL_BUSY]    = cal_busy;    // RULE_17
        clock_status[`STAT_STABLE]      = pll_stable;  // RULE_14
        clock_status[`STAT_PLL_ENABLED] = was_enabled;
    end

    always @*
    begin
        case (address)
            `OFS_PLL_CONTROL:  next_read_data = pll_control;
            `OFS_FEEDBACK_DIV: next_read_data = feedback_div;
            `OFS_PREDIV:       next_read_data = {6'h00, predivider_log2};
            `OFS_PERIOD_0:     next_read_data = system_clock_period[7:0];
            `OFS_PERIOD_1:     next_read_data = system_clock_period[15:8];
            `OFS_PERIOD_2:     next_read_data = {3'h0, system_clock_period[20:16]};
            `OFS_STAB_0:       next_read_data = stability_timer_duration[7:0];
            `OFS_STAB_1:       next_read_data = stability_timer_duration[15:8];
            `OFS_STAB_2:       next_read_data = {4'h0, stability_timer_duration[19:16]};
            `OFS_CAL_SYNC:     next_read_data = calibration_sync_control;
            `OFS_IRQ_MASK:     next_read_data = irq_mask;
            `OFS_CLOCK_STATUS: next_read_data = clock_status; // RULE_14
            `OFS_IRQ_MONITOR:  next_read_data = clock_status & irq_mask; // RULE_17
            default:           next_read_data = 8'h00;
        endcase
    end

    always @(posedge clk)
    begin
        if (reset)
        begin
            read_data          <= 8'h00;
            pll_locked         <= 1'b0;
            ref_monitor_enable <= 1'b0;
        end
        else
        begin
            // Read data stand for one cycle and are zero otherwise
            read_data          <= read_strobe ? next_read_data : 8'h00;
            pll_locked         <= detector_locked;
            // Reference monitors wait for a stable system clock
            ref_monitor_enable <= pll_stable; // RULE_18
        end
    end

endmodule
`default_nettype wire

// *** test/pll_checker.sv ***
// Assertion checker for the system clock PLL control block
`default_nettype none
module pll_checker
#(
    parameter CAL_CYCLES = 64
)
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // Register port
    input wire logic        write_strobe,
    input wire logic        read_strobe,
    input wire logic [7:0]  read_data,
    // Phase detector and PLL side
    input wire logic        pfd_sample_valid,
    input wire logic        pfd_in_phase,
    input wire logic        ext_loop_filter,
    input wire logic [7:0]  feedback_div,
    input wire logic        vco_cal_run,
    // Status
    input wire logic        pll_locked,
    input wire logic        pll_stable,
    input wire logic        ref_monitor_enable,
    input wire logic [20:0] system_clock_period
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] run;
    logic [15:0] cal_len;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////
    // Saturates so a long lock cannot wrap below the threshold
    always @(posedge clk)
    begin
        if (reset || (pfd_sample_valid && !pfd_in_phase))
            run <= 12'h000;
        else if (pfd_sample_valid && run != 12'hFFF)
            run <= run + 12'h001;
    end
    // Length of the current calibration pulse
    always @(posedge clk)
    begin
        if (reset || !vco_cal_run)
            cal_len <= 16'h0000;
        else if (cal_len != 16'hFFFF)
            cal_len <= cal_len + 16'h0001;
    end
    ////////////////////
    read_quiet_a: assert property (!$past(read_strobe) |-> read_data == 8'h00)
        else $error("read data not idle");
    lock_run_a: assert property ($rose(pll_locked) |-> run >= 12'h080)
        else $error("lock declared before a full in-phase run");
    ref_gate_a: assert property (!$past(pll_stable) |-> !ref_monitor_enable)
        else $error("reference monitors enabled before stable");
    fb_range_a: assert property (feedback_div >= 8'h06)
        else $error("feedback divider below minimum");
    // The filter select follows its register one cycle late
    cfg_hold_a: assert property (!$past(write_strobe) && !$past(write_strobe, 2) |->
        $stable({feedback_div, ext_loop_filter, system_clock_period}))
        else $error("configuration changed without a write");
    cal_cause_a: assert property ($rose(vco_cal_run) |->
        $past(write_strobe) || $past(write_strobe, 2))
        else $error("calibration started without a write");
    cal_span_a: assert property ($rose(vco_cal_run) |-> vco_cal_run[*8])
        else $error("calibration ended too early");
    cal_end_a: assert property ($rose(vco_cal_run) |-> ##[1:200] !vco_cal_run)
        else $error("calibration never ended");
    cal_length_a: assert property ($fell(vco_cal_run) |-> cal_len >= CAL_CYCLES)
        else $error("calibration shorter than its cycle count");
    cal_unlock_a: assert property (vco_cal_run[*3] |-> !pll_locked)
        else $error("lock held during calibration");
    lock_seen_c: cover property ($rose(pll_locked));
    cal_seen_c: cover property ($rose(vco_cal_run));
    stable_seen_c: cover property ($rose(pll_stable));
endmodule

bind system_clock_pll_control pll_checker #(.CAL_CYCLES(CAL_CYCLES)) pll_checker_i
(
    .clk, .reset, .write_strobe, .read_strobe, .read_data, .pfd_sample_valid,
    .pfd_in_phase, .ext_loop_filter, .feedback_div, .vco_cal_run, .pll_locked,
    .pll_stable, .ref_monitor_enable, .system_clock_period
);
`default_nettype wire

// *** test/system_clock_pll_control_tb.sv ***
// Self-checking testbench for the system clock PLL control block
`default_nettype none
`include "system_clock_pll_map.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module system_clock_pll_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // Short millisecond keeps timer runs to a few cycles
    localparam int MS = 4;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [11:0] address = 12'h000;
    logic [7:0]  write_data = 8'h00;
    logic        write_strobe = 1'b0;
    logic        read_strobe = 1'b0;
    logic        pll_enable = 1'b0;
    logic        pfd_sample_valid = 1'b0;
    logic        pfd_in_phase = 1'b0;
    logic [7:0]  read_data, feedback_div, rv;
    logic [2:0]  cp_current;
    logic [1:0]  predivider_log2;
    logic        ext_loop_filter, vco_cal_run, pll_locked, pll_stable, ref_monitor_enable;
    logic [20:0] system_clock_period;
    int          n_errors = 0;
    int          samples_checked = 0;
    int          c;

    system_clock_pll_control #(.MS_CYCLES(MS), .CAL_CYCLES(20)) system_clock_pll_control_i
    (
        .clk, .reset, .address, .write_data, .write_strobe, .read_strobe, .read_data,
        .pll_enable, .pfd_sample_valid, .pfd_in_phase, .cp_current, .ext_loop_filter,
        .feedback_div, .predivider_log2, .vco_cal_run, .pll_locked, .pll_stable,
        .ref_monitor_enable, .system_clock_period
    );
    always #10 clk = ~clk;
    ////////////////////
    // Extra edge after a write lets registered outputs settle
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clk);
        write_strobe <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clk);
        read_strobe <= 1'b0;
        #1 rv = read_data;
    endtask
    task automatic feed(input int n, input logic ph);
        repeat (n)
        begin
            @(posedge clk);
            pfd_sample_valid <= 1'b1;
            pfd_in_phase <= ph;
        end
    endtask
    task automatic idle(input int n);
        @(posedge clk);
        pfd_sample_valid <= 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic time_stable();
        c = 0;
        while (pll_stable !== 1'b1 && c < 40)
        begin
            @(posedge clk);
            #1;
            c++;
        end
        `CHK(c >= 2 * MS && c <= 2 * MS + 6, 1'b1)
    endtask
    task automatic close_out();
        $display("Mismatches %0d, comparisons %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////
    task automatic regs();
        `CHK(pll_stable, 1'b1)
        `CHK(cp_current, 3'h3)
        rd(`OFS_PLL_CONTROL);
        `CHK(rv, `CTL_RESET_VALUE)
        wr(`OFS_PLL_CONTROL, `CTL_RESET_VALUE | 8'h40);
        `CHK(cp_current, 3'h3)
        rd(`OFS_CLOCK_STATUS);
        `CHK(rv, 8'h10)
        wr(`OFS_PLL_CONTROL, 8'hE8);
        `CHK({ext_loop_filter, cp_current}, 4'hD)
        wr(`OFS_PLL_CONTROL, 8'h38);
        `CHK({ext_loop_filter, cp_current}, 4'h3)
        wr(`OFS_FEEDBACK_DIV, 8'h05);
        `CHK(feedback_div, 8'h28)
        wr(`OFS_FEEDBACK_DIV, 8'h06);
        `CHK({feedback_div, cp_current}, 11'h031)
        wr(`OFS_FEEDBACK_DIV, 8'hFF);
        `CHK({feedback_div, cp_current}, 11'h7FF)
        wr(`OFS_FEEDBACK_DIV, 8'h28);
        wr(`OFS_PERIOD_0, 8'hDE);
        wr(`OFS_PERIOD_1, 8'hBC);
        wr(`OFS_PERIOD_2, 8'h1A);
        `CHK(system_clock_period, 21'h1ABCDE)
        wr(`OFS_PREDIV, 8'h03);
        `CHK(predivider_log2, 2'h3)
    endtask
    task automatic lock_runs();
        for (int s = 0; s < 4; s++)
        begin
            wr(`OFS_PLL_CONTROL, 8'h20 | 8'(s));
            feed((128 << s) - 1, 1'b1);
            feed(1, 1'b0);
            feed((128 << s) - 1, 1'b1);
            idle(3);
            `CHK(pll_locked, 1'b0)
            feed(128 << s, 1'b1);
            idle(3);
            `CHK(pll_locked, 1'b1)
            feed(1, 1'b0);
            idle(3);
            `CHK(pll_locked, 1'b0)
        end
        wr(`OFS_STAB_0, 8'h00);
        wr(`OFS_PLL_CONTROL, 8'h24);
        feed(300, 1'b1);
        idle(3);
        `CHK(pll_locked, 1'b0)
        wr(`OFS_PLL_CONTROL, 8'h20);
    endtask
    task automatic stability();
        wr(`OFS_STAB_0, 8'h02);
        wr(`OFS_STAB_1, 8'h00);
        wr(`OFS_STAB_2, 8'h00);
        @(posedge clk);
        pll_enable <= 1'b1;
        idle(4);
        `CHK(pll_stable, 1'b0)
        feed(128, 1'b1);
        time_stable();
        rd(`OFS_CLOCK_STATUS);
        `CHK(rv[4], 1'b1)
        `CHK(ref_monitor_enable, 1'b1)
        feed(1, 1'b0);
        idle(3);
        `CHK(pll_stable, 1'b0)
        @(posedge clk);
        pll_enable <= 1'b0;
        time_stable();
    endtask
    task automatic calibrate();
        feed(128, 1'b1);
        wr(`OFS_CAL_SYNC, 8'h01);
        `CHK(pll_locked, 1'b1)
        wr(`OFS_CAL_SYNC, 8'h00);
        rd(`OFS_CLOCK_STATUS);
        `CHK(rv[1], 1'b1)
        `CHK(vco_cal_run, 1'b1)
        rd(`OFS_IRQ_MONITOR);
        `CHK(rv[1], 1'b0)
        wr(`OFS_IRQ_MASK, 8'h02);
        rd(`OFS_IRQ_MONITOR);
        `CHK(rv[1], 1'b1)
        `CHK(pll_locked, 1'b0)
        idle(20);
        `CHK(vco_cal_run, 1'b0)
    endtask
    ////////////////////
    initial
    begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        regs();
        lock_runs();
        stability();
        calibrate();
        close_out();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        close_out();
    end
endmodule
`default_nettype wire
